// ===== rtl/ahrp_link_if.sv
// Carrier between the core and the serial link logic
`timescale 1ns/1ps
interface ahrp_link_if;
   ahrp_pkg::ahrp_word_t word [ahrp_pkg::NWORD];
   logic [2:0]           nword;
   logic                 gen;
   logic                 two_wire;
   logic                 reg_sel;
   ahrp_pkg::ahrp_word_t reg_word;
   ahrp_pkg::ahrp_word_t cmd_word;
   logic                 cmd_tgl;
   modport core (output word, nword, gen, two_wire, reg_sel, reg_word,
                 input cmd_word, cmd_tgl);
   modport link (input word, nword, gen, two_wire, reg_sel, reg_word,
                 output cmd_word, cmd_tgl);
endinterface : ahrp_link_if

// ===== rtl/ahrp_pkg.sv
// Shared constants and types for the ADC host readout port
package ahrp_pkg;
   // Conversion timing
   localparam int CLK_NS    = 50;
   localparam int CONV_NS   = 500;
   localparam int CONV_CYC  = (CONV_NS + CLK_NS - 1) / CLK_NS;
   localparam int CONV_W    = 4;
   localparam logic [CONV_W-1:0] CONV_LAST = CONV_W'(CONV_CYC - 1);
   // Strap sampling waits out the two synchroniser stages
   localparam logic [1:0] STRAP_WAIT = 2'h2;
   // Word and command layout
   localparam int WORD_W  = 16;
   localparam int IDX_W   = 6;
   localparam int DAT_W   = 9;
   localparam int PAIR_W  = 3;
   localparam int NWORD   = 4;
   localparam int WR_BIT  = 15;
   localparam int IDX_MSB = 14;
   localparam int IDX_LSB = 9;
   localparam logic [IDX_W-1:0] IDX_NOP  = 6'h00;
   localparam logic [IDX_W-1:0] IDX_CFG  = 6'h02;
   localparam logic [IDX_W-1:0] IDX_CHAN = 6'h03;
   localparam logic [DAT_W-1:0] REG_RST  = 9'h000;
   localparam int CFG_STAT = 0;
   localparam int CFG_CHK  = 1;
   localparam logic [5:0] BIT_MAX = 6'h3f;
   // Synchroniser vector positions
   localparam int S_CS   = 26;
   localparam int S_RD   = 25;
   localparam int S_WR   = 24;
   localparam int S_CONV = 23;
   localparam int S_CHAN = 20;
   localparam int S_HW   = 19;
   localparam int S_SP   = 18;
   localparam int S_OW   = 17;
   localparam int S_TGL  = 16;
   localparam int SYNC_W = 27;
   localparam logic [SYNC_W-1:0] SYNC_RST = 27'h7000000;
   typedef logic [WORD_W-1:0] ahrp_word_t;
   typedef enum logic {st_idle, st_conv} ahrp_conv_t;
endpackage : ahrp_pkg

// ===== rtl/ahrp_regmem.sv
// Register store, 64 entries of 9 bits, registered read
`timescale 1ns/1ps
module ahrp_regmem (
   // Clock
   input  wire logic                       clk_in,
   input  wire logic                       ce_in,
   // Write port
   input  wire logic                       wr_en_in,
   input  wire logic [ahrp_pkg::IDX_W-1:0] wr_idx_in,
   input  wire logic [ahrp_pkg::DAT_W-1:0] wr_data_in,
   // Read port
   input  wire logic [ahrp_pkg::IDX_W-1:0] rd_idx_in,
   output logic      [ahrp_pkg::DAT_W-1:0] rd_data_out
);
   logic [ahrp_pkg::DAT_W-1:0] mem_r [2**ahrp_pkg::IDX_W];

   always_ff @(posedge clk_in) begin
      if (ce_in) begin
         if (wr_en_in) begin
            mem_r[wr_idx_in] <= wr_data_in;
         end
         rd_data_out <= mem_r[rd_idx_in];
      end
   end
endmodule : ahrp_regmem

// ===== rtl/ahrp_serial_link.sv
// Serial link logic on the host's serial clock
`timescale 1ns/1ps
module ahrp_serial_link (
   // Link clock and framing
   input  wire logic sclk_in,
   input  wire logic rst_in,
   input  wire logic select_n_in,
   input  wire logic serial_in_in,
   // Serial data
   output logic      so_a_out,
   output logic      so_b_out,
   // Core side
   ahrp_link_if.link lk
);
   logic [3:0]  fbit_r;
   logic [14:0] sh_r;
   logic [5:0]  cnt_r;
   logic        gen_seen_r;
   logic [15:0] cmd_word_r;
   logic        cmd_tgl_r;

   // Frame logic restarts whenever select is high
   wire         frame_rst = rst_in | select_n_in;
   // New results restart the readout without needing link edges
   wire [5:0]   pos  = (lk.gen != gen_seen_r) ? 6'h00 : cnt_r;
   wire [1:0]   xfer = pos[5:4];
   wire [3:0]   bsel = pos[3:0];
   wire [2:0]   ia   = (lk.two_wire && xfer != 2'h0) ? {1'b0, xfer} + 3'h1
                                                     : {1'b0, xfer};
   wire [15:0]  a_w  = (ia < lk.nword) ? lk.word[ia[1:0]] : 16'h0000;
   wire [15:0]  b_w  = (lk.two_wire && xfer == 2'h0) ? lk.word[1] : 16'h0000;

   assign so_a_out    = lk.reg_sel ? lk.reg_word[~fbit_r] : a_w[~bsel]; // [R15] [R17] [R18] [R24]
   assign so_b_out    = b_w[~bsel];                                      // [R15]
   assign lk.cmd_word = cmd_word_r;
   assign lk.cmd_tgl  = cmd_tgl_r;

   always_ff @(posedge sclk_in or posedge frame_rst) begin
      if (frame_rst) begin
         fbit_r <= 4'h0;
         sh_r   <= 15'h0000;
      end else begin
         fbit_r <= fbit_r + 4'h1;                                        // [R17]
         sh_r   <= {sh_r[13:0], serial_in_in};
      end
   end

   always_ff @(posedge sclk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_r      <= 6'h00;
         gen_seen_r <= 1'b0;
         cmd_word_r <= 16'h0000;
         cmd_tgl_r  <= 1'b0;
      end else begin
         gen_seen_r <= lk.gen;
         if (lk.reg_sel || pos == ahrp_pkg::BIT_MAX) begin
            cnt_r <= pos;
         end else begin
            cnt_r <= pos + 6'h01;                                        // [R18]
         end
         if (fbit_r == 4'hf) begin
            cmd_word_r <= {sh_r, serial_in_in};                          // [R20]
            cmd_tgl_r  <= ~cmd_tgl_r;
         end
      end
   end
endmodule : ahrp_serial_link

// ===== rtl/ahrp_top.sv
// Host readout and register port of a dual sampling ADC
//
// Overview of operation
// R1 - Hardware mode loads channel pair from pins at full or partial reset release.
// R2 - Hardware mode samples pair pins during busy for the next conversion.
// R3 - Host holds pair pins from convert rise until busy falls.
// R4 - Three-bit pair value n selects inputs VnA and VnB.
// R5 - Software mode pair comes from channel register, zero after any reset.
// R6 - Convert rising edge starts conversion; busy high; results after busy falls.
// R7 - Parallel bus driven only with select low and read strobe low.
// R8 - First read after busy gives channel A, next gives channel B.
// R9 - Status and check words add reads; host issues them all.
// R10 - Write command: bit 15 set, index in 14..9, data in 8..0.
// R11 - Parallel command word taken on write strobe rising edge.
// R12 - Register writes accepted only in software mode.
// R13 - Read command: bit 15 clear, index in 14..9, low bits ignored.
// R14 - Parallel read command copies register into output word.
// R15 - Two-wire serial: channel A on output A, channel B on output B.
// R16 - Two-wire when wire select strap high, else one wire; caught at reset.
// R17 - Select fall enables serial outputs with MSB; clock rises shift on.
// R18 - One-wire sends A then B over 32 clocks, one or two frames.
// R19 - Host keeps select low across all transfers of extended readout.
// R20 - Serial write is one 16-bit transfer, same layout.
// R21 - Serial read command is followed by another transfer.
// R22 - Serial interface when mode strap high, parallel when low.
// R23 - Mode strap caught at full reset release, later changes ignored.
// R24 - Transfer after serial read command shifts register contents out MSB first.
`timescale 1ns/1ps
module ahrp_top (
   // Clock, reset, enable
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        ce_in,
   input  wire logic        partial_rst_in,
   // Straps and channel pins
   input  wire logic        hw_mode_in,
   input  wire logic        serial_parallel_select_in,
   input  wire logic        one_wire_select_in,
   input  wire logic [2:0]  chan_pair_sel_in,
   // Conversion
   input  wire logic        convert_strobe_in,
   input  wire logic [15:0] adc_a_in,
   input  wire logic [15:0] adc_b_in,
   output logic             busy_out,
   output logic [2:0]       chan_pair_out,
   // Parallel port
   input  wire logic        select_n_pin_in,
   input  wire logic        read_strobe_n_in,
   input  wire logic        write_strobe_n_in,
   input  wire logic [15:0] parallel_data_bus_in,
   output logic [15:0]      parallel_data_bus_out,
   output logic             parallel_data_bus_oe_out,
   // Serial port
   input  wire logic        sclk_in,
   input  wire logic        serial_in_in,
   output logic             serial_out_a_out,
   output logic             serial_out_a_oe_out,
   output logic             serial_out_b_out,
   output logic             serial_out_b_oe_out,
   // Latched configuration
   output logic             hw_mode_out,
   output logic             serial_mode_out,
   output logic             two_wire_out
);
   ahrp_link_if lk ();

   // Pin synchronisers
   logic [ahrp_pkg::SYNC_W-1:0] sync1_r;
   logic [ahrp_pkg::SYNC_W-1:0] sync2_r;
   logic [ahrp_pkg::SYNC_W-1:0] prev_r;
   wire  [ahrp_pkg::SYNC_W-1:0] pin_vec = {select_n_pin_in, read_strobe_n_in,
      write_strobe_n_in, convert_strobe_in, chan_pair_sel_in, hw_mode_in,
      serial_parallel_select_in, one_wire_select_in, lk.cmd_tgl,
      parallel_data_bus_in};

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sync1_r <= ahrp_pkg::SYNC_RST;
         sync2_r <= ahrp_pkg::SYNC_RST;
         prev_r  <= ahrp_pkg::SYNC_RST;
      end else if (ce_in) begin
         sync1_r <= pin_vec;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   wire        cs_s      = sync2_r[ahrp_pkg::S_CS];
   wire        rd_s      = sync2_r[ahrp_pkg::S_RD];
   wire [2:0]  chan_s    = sync2_r[ahrp_pkg::S_CHAN +: ahrp_pkg::PAIR_W];
   wire [15:0] data_s    = sync2_r[ahrp_pkg::WORD_W-1:0];
   wire        conv_rise = sync2_r[ahrp_pkg::S_CONV] & ~prev_r[ahrp_pkg::S_CONV];
   wire        rd_fall   = ~rd_s & prev_r[ahrp_pkg::S_RD];
   wire        wr_rise   = sync2_r[ahrp_pkg::S_WR] & ~prev_r[ahrp_pkg::S_WR];
   wire        tgl_edge  = sync2_r[ahrp_pkg::S_TGL] ^ prev_r[ahrp_pkg::S_TGL];

   // Straps, caught once after full reset release
   logic [1:0] settle_r;
   logic       cfg_done_r;
   logic       hw_mode_r;
   logic       serial_r;
   logic       two_wire_r;
   wire        strap_load = ~cfg_done_r & (settle_r == ahrp_pkg::STRAP_WAIT);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         settle_r   <= 2'h0;
         cfg_done_r <= 1'b0;
         hw_mode_r  <= 1'b0;
         serial_r   <= 1'b0;
         two_wire_r <= 1'b0;
      end else if (ce_in && !cfg_done_r) begin
         settle_r <= settle_r + 2'h1;
         if (strap_load) begin
            cfg_done_r <= 1'b1;
            hw_mode_r  <= sync2_r[ahrp_pkg::S_HW];
            serial_r   <= sync2_r[ahrp_pkg::S_SP];               // [R22] [R23]
            two_wire_r <= sync2_r[ahrp_pkg::S_OW];               // [R16]
         end
      end
   end

   // Command decode, shared by both interfaces
   wire        par_cmd  = cfg_done_r & ~serial_r & ~cs_s & wr_rise;  // [R11]
   wire        ser_cmd  = cfg_done_r & serial_r & tgl_edge;          // [R20]
   wire [15:0] cmd_word = serial_r ? lk.cmd_word : data_s;
   wire        cmd_ok   = (par_cmd | ser_cmd) & ~hw_mode_r &
                          (cmd_word[ahrp_pkg::IDX_MSB:ahrp_pkg::IDX_LSB] != ahrp_pkg::IDX_NOP);
   wire        cmd_wr   = cmd_word[ahrp_pkg::WR_BIT];
   wire [5:0]  cmd_idx  = cmd_word[ahrp_pkg::IDX_MSB:ahrp_pkg::IDX_LSB];   // [R10] [R13]
   wire [8:0]  cmd_dat  = cmd_word[ahrp_pkg::DAT_W-1:0];
   wire        do_write = cmd_ok & cmd_wr;                            // [R12]
   wire        do_read  = cmd_ok & ~cmd_wr;                           // [R13]

   // Shadow copies of registers the core itself uses
   logic [8:0] cfg_reg_r;
   logic [8:0] chan_reg_r;
   logic       rd_pend_r;
   logic [5:0] rd_idx_q_r;
   logic [8:0] mem_rdata;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cfg_reg_r  <= ahrp_pkg::REG_RST;
         chan_reg_r <= ahrp_pkg::REG_RST;
         rd_pend_r  <= 1'b0;
         rd_idx_q_r <= ahrp_pkg::IDX_NOP;
      end else if (ce_in) begin
         rd_pend_r  <= do_read;
         rd_idx_q_r <= cmd_idx;
         if (partial_rst_in) begin
            chan_reg_r <= ahrp_pkg::REG_RST;                     // [R5]
         end else if (do_write && cmd_idx == ahrp_pkg::IDX_CHAN) begin
            chan_reg_r <= cmd_dat;
         end
         if (do_write && cmd_idx == ahrp_pkg::IDX_CFG) begin
            cfg_reg_r <= cmd_dat;
         end
      end
   end

   ahrp_regmem u_mem (
      .clk_in      (clk_in),
      .ce_in       (ce_in),
      .wr_en_in    (do_write),
      .wr_idx_in   (cmd_idx),
      .wr_data_in  (cmd_dat),
      .rd_idx_in   (cmd_idx),
      .rd_data_out (mem_rdata)
   );

   wire [8:0]  reg_view = (rd_idx_q_r == ahrp_pkg::IDX_CHAN) ? chan_reg_r :
                          (rd_idx_q_r == ahrp_pkg::IDX_CFG)  ? cfg_reg_r  : mem_rdata;
   wire [15:0] reg_word = {7'h00, reg_view};

   // Conversion control
   ahrp_pkg::ahrp_conv_t state_r;
   logic [3:0]  timer_r;
   logic        busy_r;
   logic [2:0]  pair_r;
   logic [2:0]  next_pair_r;
   logic [2:0]  pair_out_r;
   logic        gen_r;
   ahrp_pkg::ahrp_word_t words_r [ahrp_pkg::NWORD];
   logic [2:0]  nword_r;

   wire        stat_en    = cfg_reg_r[ahrp_pkg::CFG_STAT];
   wire        chk_en     = cfg_reg_r[ahrp_pkg::CFG_CHK];
   wire        conv_start = cfg_done_r & conv_rise & ~partial_rst_in &
                            (state_r == ahrp_pkg::st_idle);           // [R6]
   wire        conv_end   = (state_r == ahrp_pkg::st_conv) &
                            (timer_r == ahrp_pkg::CONV_LAST);
   wire        pair_load  = strap_load | (cfg_done_r & partial_rst_in);
   wire [2:0]  cur_pair   = hw_mode_r ? pair_r : chan_reg_r[ahrp_pkg::PAIR_W-1:0];  // [R4] [R5]
   wire [15:0] stat_w     = {8'h00, 1'b0, hw_mode_r, serial_r, two_wire_r,
                             1'b0, pair_out_r};
   wire [15:0] chk_w      = adc_a_in ^ adc_b_in ^ (stat_en ? stat_w : 16'h0000);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_r     <= ahrp_pkg::st_idle;
         timer_r     <= 4'h0;
         busy_r      <= 1'b0;
         pair_r      <= 3'h0;
         next_pair_r <= 3'h0;
         pair_out_r  <= 3'h0;
      end else if (ce_in) begin
         if (pair_load) begin
            pair_r      <= sync2_r[ahrp_pkg::S_CHAN +: ahrp_pkg::PAIR_W];  // [R1]
            state_r     <= ahrp_pkg::st_idle;
            busy_r      <= 1'b0;
         end else begin
            unique case (state_r)
               ahrp_pkg::st_idle: begin
                  if (conv_start) begin
                     state_r    <= ahrp_pkg::st_conv;
                     timer_r    <= 4'h0;
                     busy_r     <= 1'b1;                        // [R6]
                     pair_out_r <= cur_pair;
                  end
               end
               ahrp_pkg::st_conv: begin
                  timer_r     <= timer_r + 4'h1;
                  next_pair_r <= chan_s;                        // [R2] [R3]
                  if (conv_end) begin
                     state_r <= ahrp_pkg::st_idle;
                     busy_r  <= 1'b0;
                     if (hw_mode_r) begin
                        pair_r <= next_pair_r;                  // [R2]
                     end
                  end
               end
            endcase
         end
         if (!busy_r && !conv_start) begin
            pair_out_r <= cur_pair;
         end
      end
   end

   // Result words, frozen at busy fall so the link sees a stable set
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < ahrp_pkg::NWORD; i++) begin
            words_r[i] <= 16'h0000;
         end
         nword_r <= 3'h0;
         gen_r   <= 1'b0;
      end else if (ce_in) begin
         if (partial_rst_in) begin
            nword_r <= 3'h0;
            gen_r   <= ~gen_r;
         end else if (conv_end) begin
            words_r[0] <= adc_a_in;                             // [R8]
            words_r[1] <= adc_b_in;
            words_r[2] <= stat_en ? stat_w : chk_w;             // [R9]
            words_r[3] <= chk_w;
            nword_r    <= 3'h2 + {2'h0, stat_en} + {2'h0, chk_en};  // [R9]
            gen_r      <= ~gen_r;
         end
      end
   end

   // Parallel readout and register answers
   logic [15:0] out_word_r;
   logic [2:0]  rd_cnt_r;
   logic        reg_hold_r;
   logic        reg_sel_r;
   logic [15:0] reg_word_r;
   logic        par_oe_r;
   wire         par_rd = cfg_done_r & ~serial_r & ~cs_s & rd_fall & ~busy_r;
   wire [15:0]  rd_word = (rd_cnt_r < nword_r) ? words_r[rd_cnt_r[1:0]] : 16'h0000;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         out_word_r <= 16'h0000;
         rd_cnt_r   <= 3'h0;
         reg_hold_r <= 1'b0;
         reg_sel_r  <= 1'b0;
         reg_word_r <= 16'h0000;
         par_oe_r   <= 1'b0;
      end else if (ce_in) begin
         par_oe_r <= cfg_done_r & ~serial_r & ~cs_s & ~rd_s;    // [R7]
         if (conv_end || partial_rst_in) begin
            rd_cnt_r   <= 3'h0;
            reg_hold_r <= 1'b0;
         end else if (rd_pend_r && !serial_r) begin
            out_word_r <= reg_word;                             // [R14]
            reg_hold_r <= 1'b1;
         end else if (par_rd) begin
            if (reg_hold_r) begin
               reg_hold_r <= 1'b0;
            end else begin
               out_word_r <= rd_word;                           // [R8]
               if (rd_cnt_r != ahrp_pkg::NWORD[2:0]) begin
                  rd_cnt_r <= rd_cnt_r + 3'h1;
               end
            end
         end
         if (rd_pend_r && serial_r) begin
            reg_word_r <= reg_word;                             // [R24]
            reg_sel_r  <= 1'b1;
         end else if (ser_cmd || partial_rst_in) begin
            reg_sel_r  <= 1'b0;                                 // [R21]
         end
      end
   end

   // Hand the frozen set to the link logic
   genvar g;
   generate
      for (g = 0; g < ahrp_pkg::NWORD; g++) begin : g_words
         assign lk.word[g] = words_r[g];
      end
   endgenerate
   assign lk.nword    = nword_r;
   assign lk.gen      = gen_r;
   assign lk.two_wire = two_wire_r;
   assign lk.reg_sel  = reg_sel_r;
   assign lk.reg_word = reg_word_r;

   ahrp_serial_link u_link (
      .sclk_in      (sclk_in),
      .rst_in       (rst_in),
      .select_n_in  (select_n_pin_in),
      .serial_in_in (serial_in_in),
      .so_a_out     (serial_out_a_out),
      .so_b_out     (serial_out_b_out),
      .lk           (lk.link)
   );

   // Serial enables follow select directly so the MSB shows at once
   assign serial_out_a_oe_out = serial_r & ~select_n_pin_in;               // [R17]
   assign serial_out_b_oe_out = serial_r & two_wire_r & ~select_n_pin_in;  // [R15] [R16]

   assign busy_out                 = busy_r;
   assign chan_pair_out            = pair_out_r;
   assign parallel_data_bus_out    = out_word_r;
   assign parallel_data_bus_oe_out = par_oe_r;
   assign hw_mode_out              = hw_mode_r;
   assign serial_mode_out          = serial_r;
   assign two_wire_out             = two_wire_r;
endmodule : ahrp_top

// ===== sim/ahrp_host_model.sv
// Host serial master: select, link clock and command data
`timescale 1ns/1ps
module ahrp_host_model (
   // Host pins
   output logic      sclk_out,
   output logic      select_n_out,
   output logic      sdi_out,
   // Device data
   input  wire logic so_a_in,
   input  wire logic so_b_in
);
   initial begin
      sclk_out = 1'b0;
      select_n_out = 1'b1;
      sdi_out = 1'b0;
   end
   // One 16-clock frame; clock stands low outside frames
   task automatic frame(input logic [15:0] cmd, output logic [15:0] a, output logic [15:0] b);
      #17;
      select_n_out = 1'b0;
      #40;
      for (int i = 15; i >= 0; i--) begin
         sdi_out = cmd[i];
         a[i] = so_a_in;
         b[i] = so_b_in;
         #40 sclk_out = 1'b1;
         #80 sclk_out = 1'b0;
         #40;
      end
      select_n_out = 1'b1;
      sdi_out = ~sdi_out;
      // Gap above the minimum between commands
      #400;
   endtask : frame
endmodule : ahrp_host_model

// ===== sim/ahrp_top_asserts.sv
// Port-level checks of the ADC host readout port
`timescale 1ns/1ps
module ahrp_top_asserts (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_in,
   // Watched inputs
   input  wire logic partial_rst_in,
   input  wire logic convert_strobe_in,
   input  wire logic select_n_pin_in,
   input  wire logic read_strobe_n_in,
   // Watched outputs
   input  wire logic busy_out,
   input  wire logic parallel_data_bus_oe_out,
   input  wire logic serial_out_a_oe_out,
   input  wire logic serial_out_b_oe_out,
   input  wire logic hw_mode_out,
   input  wire logic serial_mode_out,
   input  wire logic two_wire_out
);
   logic [2:0] since_r;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // Straps are only final a few edges after release
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in)
         since_r <= 3'h0;
      else if (since_r != 3'h7)
         since_r <= since_r + 3'h1;
   end
   a_busy_len: assert property ($rose(busy_out) |->
      busy_out[*8] ##1 busy_out ##1 busy_out ##1 !busy_out) else $error("busy length wrong");
   a_busy_start: assert property ($rose(convert_strobe_in) && !busy_out &&
      !partial_rst_in && since_r == 3'h7 |-> ##[1:5] busy_out) else $error("no busy");
   a_busy_cause: assert property ($rose(busy_out) |->
      $past(convert_strobe_in, 2)) else $error("busy without convert");
   a_ser_oe: assert property (serial_out_a_oe_out ==
      (serial_mode_out && !select_n_pin_in)) else $error("serial enable wrong");
   a_oe_b_wire: assert property (serial_out_b_oe_out ==
      (serial_out_a_oe_out && two_wire_out)) else $error("second line enable wrong");
   a_par_gate: assert property ((select_n_pin_in || read_strobe_n_in)[*5] |->
      !parallel_data_bus_oe_out) else $error("bus driven while deselected");
   a_par_mode: assert property (serial_mode_out |->
      !parallel_data_bus_oe_out) else $error("bus driven in serial mode");
   a_mode_hold: assert property (since_r >= 3'h5 |-> $stable(serial_mode_out) &&
      $stable(two_wire_out) && $stable(hw_mode_out)) else $error("strap changed");
endmodule : ahrp_top_asserts
bind ahrp_top ahrp_top_asserts ahrp_top_asserts_inst (.clk_in, .rst_in, .partial_rst_in,
   .convert_strobe_in, .select_n_pin_in, .read_strobe_n_in, .busy_out,
   .parallel_data_bus_oe_out, .serial_out_a_oe_out, .serial_out_b_oe_out,
   .hw_mode_out, .serial_mode_out, .two_wire_out);

// ===== sim/ahrp_top_tb_top.sv
// Self-checking bench for the ADC host readout port
`timescale 1ns/1ps
module ahrp_top_tb_top;
   localparam logic [15:0] RES_A = 16'ha5c3;
   localparam logic [15:0] RES_B = 16'h3c5a;
   logic        clk_in, rst_in, partial_rst_in, conv_in, sel_n, rd_n, wr_n, bus_oe;
   logic        busy_out, hw_mode_out, serial_mode_out, two_wire_out, so_a, so_b;
   logic        sclk, sdi, host_sel_n;
   logic [2:0]  straps, pair, chan_pair_out;
   logic [15:0] bus_drv, bus_out, a, b;
   wire  [15:0] bus_w = bus_oe ? bus_out : bus_drv;
   wire         sel_w = sel_n & host_sel_n;
   int          bad_count, n_checks, cycles;
   ahrp_top ahrp_top_inst (.clk_in, .rst_in, .ce_in(1'b1), .partial_rst_in,
      .hw_mode_in(straps[2]), .serial_parallel_select_in(straps[1]),
      .one_wire_select_in(straps[0]), .chan_pair_sel_in(pair), .convert_strobe_in(conv_in),
      .adc_a_in(RES_A), .adc_b_in(RES_B), .busy_out, .chan_pair_out,
      .select_n_pin_in(sel_w), .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n),
      .parallel_data_bus_in(bus_w), .parallel_data_bus_out(bus_out),
      .parallel_data_bus_oe_out(bus_oe), .sclk_in(sclk), .serial_in_in(sdi),
      .serial_out_a_out(so_a), .serial_out_a_oe_out(), .serial_out_b_out(so_b),
      .serial_out_b_oe_out(), .hw_mode_out, .serial_mode_out, .two_wire_out);
   ahrp_host_model ahrp_host_model_inst (.sclk_out(sclk), .select_n_out(host_sel_n),
      .sdi_out(sdi), .so_a_in(so_a), .so_b_in(so_b));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : complete_run
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask : cyc
   task automatic full_rst(input logic [2:0] cfg, input logic [2:0] p);
      cyc(1);
      straps = cfg;
      pair = p;
      rst_in = 1'b1;
      cyc(5);
      rst_in = 1'b0;
      cyc(8);
      check({13'h0, hw_mode_out, serial_mode_out, two_wire_out}, {13'h0, cfg});
      // Later strap moves must be ignored
      straps = ~cfg;
      cyc(4);
      check({13'h0, hw_mode_out, serial_mode_out, two_wire_out}, {13'h0, cfg});
   endtask : full_rst
   task automatic conv;
      int n;
      cyc(1);
      conv_in = 1'b1;
      for (n = 0; n < 20 && busy_out !== 1'b1; n++)
         cyc(1);
      check({15'h0, busy_out}, 16'h0001);
      cyc(8);
      conv_in = 1'b0;
      for (n = 0; n < 20 && busy_out !== 1'b0; n++)
         cyc(1);
      check({15'h0, busy_out}, 16'h0000);
   endtask : conv
   task automatic par_read(output logic [15:0] w);
      sel_n = 1'b0;
      rd_n = 1'b0;
      cyc(6);
      w = bus_w;
      check({15'h0, bus_oe}, 16'h0001);
      rd_n = 1'b1;
      cyc(5);
   endtask : par_read
   task automatic par_cmd(input logic [15:0] w);
      sel_n = 1'b0;
      bus_drv = w;
      cyc(4);
      wr_n = 1'b0;
      cyc(4);
      wr_n = 1'b1;
      cyc(6);
   endtask : par_cmd
   task automatic t_par;
      logic [15:0] w;
      full_rst(3'b000, 3'h0);
      check({13'h0, chan_pair_out}, 16'h0000);
      conv();
      par_read(w);
      check(w, RES_A);
      par_read(w);
      check(w, RES_B);
      par_cmd(16'h8ba5);
      // Read command with junk in the low bits
      par_cmd(16'h0bff);
      par_read(w);
      check(w, 16'h01a5);
      par_cmd(16'h8606);
      par_cmd(16'h8403);
      conv();
      check({13'h0, chan_pair_out}, 16'h0006);
      par_read(w);
      check(w, RES_A);
      par_read(w);
      check(w, RES_B);
      par_read(w);
      check(w, 16'h0006);
      par_read(w);
      check(w, RES_A ^ RES_B ^ 16'h0006);
      sel_n = 1'b1;
      cyc(6);
   endtask : t_par
   task automatic t_hw;
      full_rst(3'b111, 3'h5);
      check({13'h0, chan_pair_out}, 16'h0005);
      pair = 3'h2;
      conv();
      ahrp_host_model_inst.frame(16'h0000, a, b);
      check(a, RES_A);
      check(b, RES_B);
      conv();
      check({13'h0, chan_pair_out}, 16'h0002);
      pair = 3'h7;
      // Pins must clear both synchroniser stages before the pulse
      cyc(3);
      partial_rst_in = 1'b1;
      cyc(1);
      partial_rst_in = 1'b0;
      cyc(6);
      check({13'h0, chan_pair_out}, 16'h0007);
   endtask : t_hw
   task automatic t_one;
      full_rst(3'b010, 3'h0);
      conv();
      ahrp_host_model_inst.frame(16'h0000, a, b);
      check(a, RES_A);
      ahrp_host_model_inst.frame(16'h0000, a, b);
      check(a, RES_B);
      ahrp_host_model_inst.frame(16'h8ac3, a, b);
      ahrp_host_model_inst.frame(16'h0a00, a, b);
      ahrp_host_model_inst.frame(16'h0000, a, b);
      check(a, 16'h00c3);
   endtask : t_one
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   initial begin
      {rst_in, partial_rst_in, conv_in, straps, pair} = 9'h100;
      {sel_n, rd_n, wr_n, bus_drv} = 19'h70000;
      t_par();
      t_hw();
      t_one();
      complete_run();
   end
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 10000) begin
         bad_count++;
         complete_run();
      end
   end
endmodule : ahrp_top_tb_top
